// >>> eeprom_cmd_pkg.sv
// constants and types shared by the serial command port
package eeprom_cmd_pkg;

  // opcode field
  localparam int          OPCODE_W        = 2;
  localparam logic [1:0]  OP_SPECIAL      = 2'h0;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_ERASE        = 2'h3;

  // special command selected by the top two address bits
  localparam logic [1:0]  SUB_DISABLE     = 2'h0;
  localparam logic [1:0]  SUB_WRITE_ALL   = 2'h1;
  localparam logic [1:0]  SUB_ERASE_ALL   = 2'h2;
  localparam logic [1:0]  SUB_ENABLE      = 2'h3;

  // organisation
  localparam logic [4:0]  ADDR_BITS_WORD  = 5'h06;
  localparam logic [4:0]  ADDR_BITS_BYTE  = 5'h07;
  localparam logic [4:0]  DATA_BITS_WORD  = 5'h10;
  localparam logic [4:0]  DATA_BITS_BYTE  = 5'h08;
  localparam int          WORDS           = 64;
  localparam int          WORD_W          = 16;
  localparam int          BYTE_W          = 8;
  localparam int          ADDR_W          = 7;
  localparam int          INDEX_W         = 6;
  localparam int          CMD_W           = OPCODE_W + ADDR_W;
  localparam logic [15:0] ERASED_WORD     = 16'hffff;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // self-timed programming cycle, longest time rounded down
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned PROG_TIME_NS    = 10_000_000;
  localparam int unsigned PROG_CYCLES     = PROG_TIME_NS / CLK_PERIOD_NS;

  // gray coded along idle, command, data, armed, program
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_CMD     = 3'h1,
    ST_DATA    = 3'h3,
    ST_ARMED   = 3'h2,
    ST_PROGRAM = 3'h6,
    ST_READ    = 3'h7,
    ST_HOLD    = 3'h5
  } port_state_t;

endpackage : eeprom_cmd_pkg

// >>> eeprom_port_sva.sv
// assertions for the serial command port
`timescale 1ns/100ps
`default_nettype none

module eeprom_port_sva
#(
  parameter int unsigned progCycles = 200000
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic chipSelect,
  input wire logic serialClockIn,
  input wire logic serialIn,
  input wire logic widthSelect,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic programBusy
);
  logic [31:0] busyCnt_ff;
  logic        skPrev_ff;
  logic [7:0]  skAge_ff;

  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // length of the running programming cycle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !programBusy)
      busyCnt_ff <= 32'h0;
    else
      busyCnt_ff <= busyCnt_ff + 32'h1;
  end

  // cycles since the serial clock pin last rose
  always_ff @(posedge clk_sys)
  begin
    skPrev_ff <= serialClockIn;
    if (serialClockIn && !skPrev_ff)
      skAge_ff <= 8'h0;
    else if (skAge_ff != 8'hff)
      skAge_ff <= skAge_ff + 8'h1;
  end

  AST_RST_QUIET: assert property (disable iff (1'b0)
    sys_rst |=> !serialOutEn && !programBusy) else $error("outputs active after reset");
  AST_DESEL_FLOAT: assert property (!chipSelect [*6] |-> !serialOutEn)
    else $error("output driven while deselected");
  AST_EN_SEL: assert property ($rose(serialOutEn) |-> chipSelect)
    else $error("output enabled without select");
  AST_BUSY_START: assert property ($rose(programBusy) |-> !chipSelect)
    else $error("cycle started while selected");
  AST_BUSY_LEN: assert property ($fell(programBusy) |->
    busyCnt_ff inside {[progCycles - 1 : progCycles + 2]}) else $error("cycle length wrong");
  AST_BUSY_MAX: assert property (busyCnt_ff <= progCycles + 2)
    else $error("cycle overruns");
  AST_BUSY_LOW: assert property (programBusy && $past(programBusy) && serialOutEn
    |-> !serialOut) else $error("status high while busy");
  AST_RD_EDGE: assert property (serialOutEn && $past(serialOutEn) && $changed(serialOut)
    && !$past(programBusy, 3) |-> skAge_ff inside {[1:6]}) else $error("output moved off edge");
  AST_RELEASE: assert property (serialOutEn && serialOut && !programBusy && serialIn
    && $rose(serialClockIn) |-> ##[1:12] !serialOutEn) else $error("status not released");
endmodule : eeprom_port_sva

bind serial_eeprom_command_port eeprom_port_sva #(.progCycles(progCycles)) eeprom_port_sva_i
(
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .chipSelect(chipSelect),
  .serialClockIn(serialClockIn),
  .serialIn(serialIn),
  .widthSelect(widthSelect),
  .serialOut(serialOut),
  .serialOutEn(serialOutEn),
  .programBusy(programBusy)
);

`default_nettype wire

// >>> host_model.sv
// host microcontroller model driving the three-wire serial bus
`timescale 1ns/100ps
`default_nettype none

module host_model
(
  input  wire logic clk_sys,
  input  wire logic doLine,
  output var  logic chipSelect,
  output var  logic serialClockIn,
  output var  logic serialIn
);
  // bus idle, serial clock parked low
  initial
  begin
    chipSelect    = 1'b0;
    serialClockIn = 1'b0;
    serialIn      = 1'b0;
  end

  // hold for n falling edges of the system clock
  task automatic waitN(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : waitN

  // one 400 ns serial clock period; line sampled just before the rise
  task automatic bitx(input logic b, output logic so);
    serialIn = b;
    waitN(4);
    so = doLine;
    serialClockIn = 1'b1;
    waitN(4);
    serialClockIn = 1'b0;
  endtask : bitx

  // select and let the port synchronise
  task automatic select();
    chipSelect = 1'b1;
    waitN(4);
  endtask : select

  // 400 ns low time; data line no longer holds its value
  task automatic deselect();
    chipSelect = 1'b0;
    serialIn   = ~serialIn;
    waitN(8);
  endtask : deselect
endmodule : host_model

`default_nettype wire

// >>> pin_sync_edge.sv
// two-flop pin synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none

module pin_sync_edge
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  output var  logic level,
  output var  logic rise,
  output var  logic fall
);

  logic meta_ff;
  logic stable_ff;
  logic prev_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta_ff   <= 1'b0;
      stable_ff <= 1'b0;
      prev_ff   <= 1'b0;
    end
    else
    begin
      meta_ff   <= pinIn;
      stable_ff <= meta_ff;
      prev_ff   <= stable_ff;
    end
  end

  // level and edges from settled stages
  always_comb
  begin
    level = stable_ff;
    rise  = stable_ff & ~prev_ff;
    fall  = ~stable_ff & prev_ff;
  end

endmodule : pin_sync_edge

`default_nettype wire

// >>> serial_eeprom_command_port.sv
// three-wire serial command port of a 1 kbit nonvolatile memory
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_command_port
#(
  parameter int unsigned progCycles = eeprom_cmd_pkg::PROG_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic chipSelect,
  input  wire logic serialClockIn,
  input  wire logic serialIn,
  input  wire logic widthSelect,
  output var  logic serialOut,
  output var  logic serialOutEn,
  output var  logic programBusy
);

  // address bits for the organisation in use
  function automatic logic [4:0] addrBits(input logic byteMode);
    addrBits = byteMode ? eeprom_cmd_pkg::ADDR_BITS_BYTE : eeprom_cmd_pkg::ADDR_BITS_WORD;
  endfunction : addrBits

  // data bits for the organisation in use
  function automatic logic [4:0] dataBits(input logic byteMode);
    dataBits = byteMode ? eeprom_cmd_pkg::DATA_BITS_BYTE : eeprom_cmd_pkg::DATA_BITS_WORD;
  endfunction : dataBits

  // word index for an address
  function automatic logic [5:0] wordIndex(input logic [6:0] addr, input logic byteMode);
    wordIndex = byteMode ? addr[6:1] : addr[5:0];
  endfunction : wordIndex

  logic                     csLvl;
  logic                     csFall;
  logic                     csRise;
  logic                     skRise;
  logic                     skFall;
  logic                     diLvl;
  logic                     orgLvl;

  eeprom_cmd_pkg::port_state_t state_ff;
  logic [4:0]               bitCnt_ff;
  logic [8:0]               cmd_ff;
  logic [15:0]              data_ff;
  logic [15:0]              readWord_ff;
  logic [1:0]               opcode_ff;
  logic [1:0]               special_ff;
  logic [6:0]               addr_ff;
  logic                     byteMode_ff;
  logic                     enabled_ff;
  logic [31:0]              progCnt_ff;
  logic                     statusPending_ff;
  logic                     releaseArm_ff;
  logic [15:0]              mem_ff [eeprom_cmd_pkg::WORDS];

  logic [8:0]               nxtCmd;
  logic [1:0]               nxtOpcode;
  logic [6:0]               nxtAddr;
  logic [1:0]               nxtSpecial;
  logic                     cmdDone;
  logic                     dataDone;
  logic                     readLast;
  logic                     progDone;
  logic                     startSeen;

  // pin synchronisers
  pin_sync_edge csSync
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (chipSelect),
    .level   (csLvl),
    .rise    (csRise),
    .fall    (csFall)
  );

  pin_sync_edge skSync
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (serialClockIn),
    .level   (),
    .rise    (skRise),
    .fall    (skFall)
  );

  pin_sync_edge diSync
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (serialIn),
    .level   (diLvl),
    .rise    (),
    .fall    ()
  );

  pin_sync_edge orgSync
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pinIn   (widthSelect),
    .level   (orgLvl),
    .rise    (),
    .fall    ()
  );

  // command field decode from the bit being shifted in
  always_comb
  begin
    nxtCmd     = {cmd_ff[7:0], diLvl};
    nxtOpcode  = byteMode_ff ? nxtCmd[8:7] : nxtCmd[7:6];
    nxtAddr    = byteMode_ff ? nxtCmd[6:0] : {1'b0, nxtCmd[5:0]};
    nxtSpecial = byteMode_ff ? nxtCmd[6:5] : nxtCmd[5:4];
    cmdDone    = (state_ff == eeprom_cmd_pkg::ST_CMD) && skRise && csLvl
                 && (bitCnt_ff == 5'(eeprom_cmd_pkg::OPCODE_W) + addrBits(byteMode_ff) - 5'h01);
    dataDone   = (state_ff == eeprom_cmd_pkg::ST_DATA) && skRise && csLvl
                 && (bitCnt_ff == dataBits(byteMode_ff) - 5'h01);
    readLast   = (bitCnt_ff == dataBits(byteMode_ff));
    progDone   = (state_ff == eeprom_cmd_pkg::ST_PROGRAM)
                 && (progCnt_ff == 32'(progCycles - 1));
    startSeen  = (state_ff == eeprom_cmd_pkg::ST_IDLE) && !statusPending_ff
                 && csLvl && skRise && diLvl;
  end

  // command sequencer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_ff    <= eeprom_cmd_pkg::ST_IDLE;
      bitCnt_ff   <= 5'h00;
      cmd_ff      <= 9'h000;
      data_ff     <= 16'h0000;
      readWord_ff <= 16'h0000;
      opcode_ff   <= eeprom_cmd_pkg::OP_SPECIAL;
      special_ff  <= eeprom_cmd_pkg::SUB_DISABLE;
      addr_ff     <= 7'h00;
      byteMode_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        eeprom_cmd_pkg::ST_IDLE:
        begin
          if (startSeen)
          begin
            state_ff    <= eeprom_cmd_pkg::ST_CMD;
            bitCnt_ff   <= 5'h00;
            cmd_ff      <= 9'h000;
            byteMode_ff <= ~orgLvl;
          end
        end
        eeprom_cmd_pkg::ST_CMD:
        begin
          if (csFall)
            state_ff <= eeprom_cmd_pkg::ST_IDLE;
          else if (skRise && csLvl)
          begin
            cmd_ff    <= nxtCmd;
            bitCnt_ff <= bitCnt_ff + 5'h01;
            if (cmdDone)
            begin
              opcode_ff  <= nxtOpcode;
              special_ff <= nxtSpecial;
              addr_ff    <= nxtAddr;
              bitCnt_ff  <= 5'h00;
              case (nxtOpcode)
                eeprom_cmd_pkg::OP_READ:
                begin
                  state_ff <= eeprom_cmd_pkg::ST_READ;
                  if (byteMode_ff)
                    readWord_ff <= nxtAddr[0]
                      ? {mem_ff[wordIndex(nxtAddr, 1'b1)][15:8], eeprom_cmd_pkg::ZERO_BYTE}
                      : {mem_ff[wordIndex(nxtAddr, 1'b1)][7:0], eeprom_cmd_pkg::ZERO_BYTE};
                  else
                    readWord_ff <= mem_ff[wordIndex(nxtAddr, 1'b0)];
                end
                eeprom_cmd_pkg::OP_WRITE:
                  state_ff <= eeprom_cmd_pkg::ST_DATA;
                eeprom_cmd_pkg::OP_ERASE:
                  state_ff <= eeprom_cmd_pkg::ST_ARMED;
                default:
                begin
                  case (nxtSpecial)
                    eeprom_cmd_pkg::SUB_WRITE_ALL: state_ff <= eeprom_cmd_pkg::ST_DATA;
                    eeprom_cmd_pkg::SUB_ERASE_ALL: state_ff <= eeprom_cmd_pkg::ST_ARMED;
                    default:                       state_ff <= eeprom_cmd_pkg::ST_HOLD;
                  endcase
                end
              endcase
            end
          end
        end
        eeprom_cmd_pkg::ST_DATA:
        begin
          if (csFall)
            state_ff <= eeprom_cmd_pkg::ST_IDLE;
          else if (skRise && csLvl)
          begin
            data_ff   <= {data_ff[14:0], diLvl};
            bitCnt_ff <= bitCnt_ff + 5'h01;
            if (dataDone)
              state_ff <= eeprom_cmd_pkg::ST_ARMED;
          end
        end
        eeprom_cmd_pkg::ST_ARMED:
        begin
          if (csFall)
            state_ff <= enabled_ff ? eeprom_cmd_pkg::ST_PROGRAM
                                   : eeprom_cmd_pkg::ST_IDLE;
        end
        eeprom_cmd_pkg::ST_PROGRAM:
        begin
          if (progDone)
            state_ff <= eeprom_cmd_pkg::ST_IDLE;
        end
        eeprom_cmd_pkg::ST_READ:
        begin
          if (csFall)
            state_ff <= eeprom_cmd_pkg::ST_IDLE;
          else if (skRise)
          begin
            readWord_ff <= {readWord_ff[14:0], 1'b0};
            bitCnt_ff   <= bitCnt_ff + 5'h01;
            if (readLast)
              state_ff <= eeprom_cmd_pkg::ST_HOLD;
          end
        end
        eeprom_cmd_pkg::ST_HOLD:
        begin
          if (csFall)
            state_ff <= eeprom_cmd_pkg::ST_IDLE;
        end
        default:
          state_ff <= eeprom_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // programming enable latch, cleared at reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      enabled_ff <= 1'b0;
    else if (cmdDone && nxtOpcode == eeprom_cmd_pkg::OP_SPECIAL)
    begin
      if (nxtSpecial == eeprom_cmd_pkg::SUB_ENABLE)
        enabled_ff <= 1'b1;
      else if (nxtSpecial == eeprom_cmd_pkg::SUB_DISABLE)
        enabled_ff <= 1'b0;
    end
  end

  // self-timed cycle counter on the system clock
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      progCnt_ff <= 32'h0000_0000;
    else if (state_ff == eeprom_cmd_pkg::ST_PROGRAM)
      progCnt_ff <= progCnt_ff + 32'h0000_0001;
    else
      progCnt_ff <= 32'h0000_0000;
  end

  // status presentation after a cycle, ended by dummy one or deselect
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      statusPending_ff <= 1'b0;
      releaseArm_ff    <= 1'b0;
    end
    else if (state_ff == eeprom_cmd_pkg::ST_ARMED && csFall && enabled_ff)
    begin
      statusPending_ff <= 1'b1;
      releaseArm_ff    <= 1'b0;
    end
    else if (state_ff == eeprom_cmd_pkg::ST_IDLE && statusPending_ff)
    begin
      if (csFall || (skFall && releaseArm_ff))
      begin
        statusPending_ff <= 1'b0;
        releaseArm_ff    <= 1'b0;
      end
      else if (csLvl && skRise && diLvl)
        releaseArm_ff <= 1'b1;
      else if (csRise)
        releaseArm_ff <= 1'b0; // fresh selection starts unarmed
    end
  end

  // memory array, erased at reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < eeprom_cmd_pkg::WORDS; i++)
        mem_ff[i] <= eeprom_cmd_pkg::ERASED_WORD;
    end
    else if (progDone)
    begin
      case (opcode_ff)
        eeprom_cmd_pkg::OP_ERASE:
        begin
          if (byteMode_ff && addr_ff[0])
            mem_ff[wordIndex(addr_ff, 1'b1)][15:8] <= eeprom_cmd_pkg::ERASED_WORD[15:8];
          else if (byteMode_ff)
            mem_ff[wordIndex(addr_ff, 1'b1)][7:0] <= eeprom_cmd_pkg::ERASED_WORD[7:0];
          else
            mem_ff[wordIndex(addr_ff, 1'b0)] <= eeprom_cmd_pkg::ERASED_WORD;
        end
        eeprom_cmd_pkg::OP_WRITE:
        begin
          if (byteMode_ff && addr_ff[0])
            mem_ff[wordIndex(addr_ff, 1'b1)][15:8] <= data_ff[7:0];
          else if (byteMode_ff)
            mem_ff[wordIndex(addr_ff, 1'b1)][7:0] <= data_ff[7:0];
          else
            mem_ff[wordIndex(addr_ff, 1'b0)] <= data_ff;
        end
        default:
        begin
          for (int i = 0; i < eeprom_cmd_pkg::WORDS; i++)
          begin
            if (special_ff == eeprom_cmd_pkg::SUB_ERASE_ALL)
              mem_ff[i] <= eeprom_cmd_pkg::ERASED_WORD;
            else if (special_ff == eeprom_cmd_pkg::SUB_WRITE_ALL && byteMode_ff)
              mem_ff[i] <= mem_ff[i] & {data_ff[7:0], data_ff[7:0]};
            else if (special_ff == eeprom_cmd_pkg::SUB_WRITE_ALL)
              mem_ff[i] <= mem_ff[i] & data_ff;
          end
        end
      endcase
    end
  end

  // serial output driver and busy flag
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      serialOut   <= 1'b0;
      serialOutEn <= 1'b0;
      programBusy <= 1'b0;
    end
    else
    begin
      programBusy <= (state_ff == eeprom_cmd_pkg::ST_ARMED && csFall && enabled_ff)
                     || (state_ff == eeprom_cmd_pkg::ST_PROGRAM && !progDone);
      case (state_ff)
        eeprom_cmd_pkg::ST_PROGRAM:
        begin
          serialOutEn <= csLvl;
          serialOut   <= progDone;
        end
        eeprom_cmd_pkg::ST_READ:
        begin
          if (csFall || (skRise && readLast))
            serialOutEn <= 1'b0;
          else if (skRise)
            serialOut <= readWord_ff[eeprom_cmd_pkg::WORD_W - 1];
        end
        default:
        begin
          if (state_ff == eeprom_cmd_pkg::ST_IDLE && statusPending_ff)
          begin
            serialOutEn <= csLvl && !csFall && !(skFall && releaseArm_ff);
            serialOut   <= 1'b1;
          end
          else if (cmdDone && nxtOpcode == eeprom_cmd_pkg::OP_READ)
          begin
            serialOutEn <= 1'b1;
            serialOut   <= 1'b0;
          end
          else
            serialOutEn <= 1'b0;
        end
      endcase
    end
  end

endmodule : serial_eeprom_command_port

`default_nettype wire

// >>> serial_eeprom_command_port_bench.sv
// self-checking bench for the serial command port
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_command_port_bench;
  // organisation, opcode, address or special code, data, word read or busy
  typedef struct packed {
    logic        width_select;
    logic [1:0]  op;
    logic [6:0]  a;
    logic [15:0] d;
    logic [15:0] exp;
  } row_t;

  logic clk_sys;
  logic sys_rst;
  logic widthSelect;
  logic chipSelect;
  logic serialClockIn;
  logic serialIn;
  logic serialOut;
  logic serialOutEn;
  logic programBusy;
  wire  doLine;
  int   checked = 0;
  int   err_count = 0;

  // op 2 read, 1 write, 3 erase, 0 special
  row_t rows [20] = '{
    {1'b1, 2'h2, 7'h05, 16'h0, 16'hffff},
    {1'b1, 2'h1, 7'h05, 16'h1234, 16'h0},
    {1'b1, 2'h2, 7'h05, 16'h0, 16'hffff},
    {1'b1, 2'h0, 7'h03, 16'h0, 16'h0},
    {1'b1, 2'h1, 7'h05, 16'h1234, 16'h1},
    {1'b1, 2'h2, 7'h05, 16'h0, 16'h1234},
    {1'b1, 2'h3, 7'h05, 16'h0, 16'h1},
    {1'b1, 2'h2, 7'h05, 16'h0, 16'hffff},
    {1'b1, 2'h1, 7'h03, 16'h00ff, 16'h1},
    {1'b1, 2'h0, 7'h02, 16'h0, 16'h1},
    {1'b1, 2'h2, 7'h03, 16'h0, 16'hffff},
    {1'b1, 2'h0, 7'h01, 16'ha5c3, 16'h1},
    {1'b1, 2'h2, 7'h3f, 16'h0, 16'ha5c3},
    {1'b0, 2'h1, 7'h0b, 16'h003c, 16'h1},
    {1'b0, 2'h2, 7'h0b, 16'h0, 16'h003c},
    {1'b0, 2'h2, 7'h0a, 16'h0, 16'h00c3},
    {1'b1, 2'h2, 7'h05, 16'h0, 16'h3cc3},
    {1'b1, 2'h0, 7'h00, 16'h0, 16'h0},
    {1'b1, 2'h1, 7'h05, 16'h0, 16'h0},
    {1'b1, 2'h2, 7'h05, 16'h0, 16'h3cc3}
  };

  // shared data line, floats when the port lets go
  assign doLine = serialOutEn ? serialOut : 1'bz;

  serial_eeprom_command_port #(.progCycles(150)) serial_eeprom_command_port_i
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .chipSelect(chipSelect),
    .serialClockIn(serialClockIn),
    .serialIn(serialIn),
    .widthSelect(widthSelect),
    .serialOut(serialOut),
    .serialOutEn(serialOutEn),
    .programBusy(programBusy)
  );

  host_model host_model_i
  (
    .clk_sys(clk_sys),
    .doLine(doLine),
    .chipSelect(chipSelect),
    .serialClockIn(serialClockIn),
    .serialIn(serialIn)
  );

  // 20 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // single bit result
  task automatic cmpBit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask : cmpBit

  // word result
  task automatic cmpWord(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmpWord

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // cycle start, busy status with ignored command, ready status, release
  task automatic pollBusy(input logic e);
    logic so;
    cmpBit("busy", e, programBusy);
    if (e)
    begin
      host_model_i.select();
      host_model_i.waitN(4);
      cmpBit("status busy", 1'b0, doLine);
      repeat (9) host_model_i.bitx(1'b1, so);
      host_model_i.deselect();
      for (int k = 0; k < 400 && programBusy; k++)
        host_model_i.waitN(1);
      cmpBit("cycle end", 1'b0, programBusy);
      host_model_i.select();
      host_model_i.waitN(4);
      cmpBit("status ready", 1'b1, doLine);
      host_model_i.bitx(1'b1, so);
      host_model_i.waitN(6);
      cmpBit("status release", 1'bz, doLine);
      host_model_i.deselect();
    end
  endtask : pollBusy

  // one instruction frame, read data gathered bit by bit and checked as one word
  task automatic doCmd(input row_t r);
    int          aw;
    int          dw;
    logic [6:0]  a;
    logic        so;
    logic [15:0] got;
    aw = r.width_select ? 6 : 7;
    dw = r.width_select ? 16 : 8;
    a = (r.op == 2'h0) ? 7'(r.a << (aw - 2)) : r.a;
    got = 16'h0;
    widthSelect = r.width_select;
    host_model_i.select();
    host_model_i.bitx(1'b1, so);
    for (int i = 1; i >= 0; i--)
      host_model_i.bitx(r.op[i], so);
    for (int i = aw - 1; i >= 0; i--)
      host_model_i.bitx(a[i], so);
    if (r.op == 2'h1 || (r.op == 2'h0 && r.a[1:0] == 2'h1))
      for (int i = dw - 1; i >= 0; i--)
        host_model_i.bitx(r.d[i], so);
    if (r.op == 2'h2)
    begin
      host_model_i.bitx(1'b0, so);
      cmpBit("dummy bit", 1'b0, so);
      for (int i = dw - 1; i >= 0; i--)
      begin
        host_model_i.bitx(1'b0, so);
        got[i] = so;
      end
      host_model_i.waitN(6);
      cmpBit("read release", 1'bz, doLine);
      cmpWord("read data", r.exp, got);
    end
    host_model_i.deselect();
    if (r.op == 2'h3 || r.op == 2'h1 || (r.op == 2'h0 && r.a[1] != r.a[0]))
      pollBusy(r.exp[0]);
  endtask : doCmd

  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    widthSelect = 1'b1;
    repeat (5) @(negedge clk_sys);
    cmpBit("reset oe", 1'b0, serialOutEn);
    cmpBit("reset busy", 1'b0, programBusy);
    $display("reset test done");
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i])
    begin
      doCmd(rows[i]);
      $display("row %0d done", i);
    end
    doCmd({1'b1, 2'h0, 7'h03, 16'h0, 16'h0});
    sys_rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    doCmd({1'b1, 2'h1, 7'h05, 16'h0, 16'h0});
    doCmd({1'b1, 2'h2, 7'h05, 16'h0, 16'hffff});
    $display("mid-run reset done");
    results();
  end

  // hang guard
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    results();
  end
endmodule : serial_eeprom_command_port_bench

`default_nettype wire
